// [core/usb_endpoint_handshake_ctrl.sv]
// endpoint handshake and status flags for five endpoints, control-transfer sequencing for hub ep0 and function ep0
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "ep_hs_cfg.svh"

module usb_endpoint_handshake_ctrl
    import ep_hs_pkg::*;
#(
    parameter int NUM_EP = 5,
    parameter int ADDR_W = 13
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // transaction side: index 0 hub ep0, 1 function ep0, 2..4 function ep1..3
    input wire logic [2:0] tok_ep_i,
    input wire logic [2:0] tok_kind_i,
    input wire logic tok_valid_i,
    input wire logic [NUM_EP-1:0] ep_iso_i,
    input wire logic in_host_ack_i,
    input wire logic in_sent_i,
    input wire logic out_stored_i,
    input wire logic setup_stored_i,
    output logic [2:0] reply_o,
    output logic reply_data1_o,
    output logic fifo_write_ok_o,
    output logic irq_o
);

    logic rst_meta_n;
    logic rst_n;
    logic [NUM_EP-1:0] dir_bit;
    logic [NUM_EP-1:0] data_end;
    logic [NUM_EP-1:0] stall_req;
    logic [NUM_EP-1:0] in_loaded;
    logic [NUM_EP-1:0] stall_sent;
    logic [NUM_EP-1:0] setup_rx;
    logic [NUM_EP-1:0] out_rx;
    logic [NUM_EP-1:0] in_done;
    logic [NUM_EP-1:0] irq_en;
    logic [NUM_EP-1:0] is_ctrl;
    phase_t phase [NUM_EP];
    logic [2:0] cur_ep;
    token_t cur_tok;
    logic [2:0] next_reply;
    logic next_data1;
    logic [NUM_EP-1:0] ev_stall;
    logic [NUM_EP-1:0] ev_in_clr;
    logic [NUM_EP-1:0] ev_out;
    logic [NUM_EP-1:0] ev_setup;
    logic [NUM_EP-1:0] ev_in_done;
    logic [NUM_EP-1:0] ev_status_end;
    logic [NUM_EP-1:0] ctl_sel;
    logic [NUM_EP-1:0] sts_sel;
    logic [NUM_EP-1:0] irq_hit;
    logic [7:0] next_rdata;

    // reset released through two flops so release is clean against clk_sys_i
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    assign cur_ep = tok_ep_i;
    assign cur_tok = token_t'(tok_kind_i);

    // handshake choice for the token presented this cycle
    always_comb
    begin
        next_reply = HS_NONE;
        next_data1 = 1'b0;
        if (tok_valid_i && (int'(cur_ep) < NUM_EP))
        begin
            if (cur_tok == TOK_SETUP)
            begin
                next_reply = HS_ACK;
            end
            else if (stall_req[cur_ep])
            begin
                next_reply = HS_STALL;
            end
            else if (cur_tok == TOK_OUT)
            begin
                if (out_rx[cur_ep])
                begin
                    next_reply = HS_NAK;
                end
                else
                begin
                    next_reply = HS_ACK;
                end
            end
            else if (cur_tok == TOK_IN)
            begin
                if (in_loaded[cur_ep])
                begin
                    next_reply = HS_DATA;
                    next_data1 = is_ctrl[cur_ep] && (phase[cur_ep] == PH_STATUS);
                end
                else if (is_ctrl[cur_ep] && data_end[cur_ep] && !dir_bit[cur_ep])
                begin
                    // zero length status packet, always DATA1
                    next_reply = HS_DATA;
                    next_data1 = 1'b1;
                end
                else
                begin
                    next_reply = HS_NAK;
                end
            end
        end
    end

    // one flop per reply output keeps the link side glitch free
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reply_o <= 3'h0;
            reply_data1_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            reply_o <= next_reply;
            reply_data1_o <= next_data1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            localparam logic [2:0] EP_IDX = 3'(g);
            logic hit;
            logic [ADDR_W-1:0] ctl_addr;
            logic [ADDR_W-1:0] sts_addr;
            assign is_ctrl[g] = (g < 2);
            assign hit = tok_valid_i && (cur_ep == EP_IDX);
            assign ctl_addr = (g == 0) ? ADDR_W'(`EP_HS_HUB_EP0_CTRL_ACK) :
                              (g == 1) ? ADDR_W'(`EP_HS_FN_EP0_CTRL_ACK) :
                              (g == 2) ? ADDR_W'(`EP_HS_FN_EP1_CTRL_ACK) :
                              (g == 3) ? ADDR_W'(`EP_HS_FN_EP2_CTRL_ACK) :
                              ADDR_W'(`EP_HS_FN_EP3_CTRL_ACK);
            assign sts_addr = (g == 0) ? ADDR_W'(`EP_HS_HUB_EP0_STATUS) :
                              (g == 1) ? ADDR_W'(`EP_HS_FN_EP0_CTRL_ACK) :
                              (g == 2) ? ADDR_W'(`EP_HS_FN_EP1_STATUS) :
                              (g == 3) ? ADDR_W'(`EP_HS_FN_EP2_STATUS) :
                              ADDR_W'(`EP_HS_FN_EP3_STATUS);
            assign ctl_sel[g] = reg_wr_i && (reg_addr_i == ctl_addr);
            assign sts_sel[g] = (reg_addr_i == sts_addr);

            // transaction events; stall only counts when actually replied
            assign ev_stall[g] = hit && (cur_tok != TOK_SETUP) && (cur_tok != TOK_NONE)
                && stall_req[g];
            // only a setup token may open a control transfer
            assign ev_setup[g] = hit && is_ctrl[g] && (cur_tok == TOK_SETUP) && setup_stored_i;
            assign ev_out[g] = hit && (cur_tok == TOK_OUT) && out_stored_i && !out_rx[g]
                && !stall_req[g];
            assign ev_in_clr[g] = hit && (cur_tok == TOK_IN) && in_loaded[g] && !stall_req[g]
                && (in_host_ack_i || (ep_iso_i[g] && in_sent_i));
            // status phase end: zero length IN acked, or status OUT stored after a read
            assign ev_status_end[g] = is_ctrl[g] && hit && !stall_req[g] && (phase[g] == PH_STATUS)
                && (((cur_tok == TOK_IN) && in_host_ack_i && !dir_bit[g])
                || ((cur_tok == TOK_OUT) && out_stored_i && dir_bit[g]));
            assign ev_in_done[g] = is_ctrl[g] ? (ev_status_end[g]
                || (ev_in_clr[g] && dir_bit[g] && data_end[g]))
                : ev_in_clr[g];

            // control phase tracking per control endpoint
            always_ff @(posedge clk_sys_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    phase[g] <= PH_IDLE;
                end
                else if (clk_en_i)
                begin
                    if (!is_ctrl[g])
                    begin
                        phase[g] <= PH_IDLE;
                    end
                    else if (ev_setup[g])
                    begin
                        phase[g] <= PH_DATA;
                    end
                    else if (ev_status_end[g])
                    begin
                        phase[g] <= PH_IDLE;
                    end
                    else if (phase[g] == PH_DATA && data_end[g] && !in_loaded[g])
                    begin
                        phase[g] <= PH_STATUS;
                    end
                end
            end

            // firmware control bits; hardware clears only the IN loaded bit
            always_ff @(posedge clk_sys_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    dir_bit[g] <= 1'b0;
                    data_end[g] <= 1'b0;
                    stall_req[g] <= 1'b0;
                    in_loaded[g] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    if (ctl_sel[g])
                    begin
                        dir_bit[g] <= is_ctrl[g] && reg_wdata_i[`EP_HS_BIT_DIR];
                        data_end[g] <= reg_wdata_i[`EP_HS_BIT_DATA_END];
                        stall_req[g] <= reg_wdata_i[`EP_HS_BIT_STALL_REQ];
                    end
                    if (ev_in_clr[g])
                    begin
                        in_loaded[g] <= 1'b0;
                    end
                    else if (ctl_sel[g])
                    begin
                        in_loaded[g] <= reg_wdata_i[`EP_HS_BIT_IN_LOADED];
                    end
                end
            end

            // sticky status: hardware set wins over a same-cycle ack
            always_ff @(posedge clk_sys_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    stall_sent[g] <= 1'b0;
                    setup_rx[g] <= 1'b0;
                    out_rx[g] <= 1'b0;
                    in_done[g] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    if (ev_setup[g])
                    begin
                        setup_rx[g] <= 1'b1;
                        stall_sent[g] <= 1'b0;
                        out_rx[g] <= 1'b0;
                        in_done[g] <= 1'b0;
                    end
                    else
                    begin
                        if (ev_stall[g])
                            stall_sent[g] <= 1'b1;
                        else if (ctl_sel[g] && reg_wdata_i[`EP_HS_BIT_STALL_SENT])
                            stall_sent[g] <= 1'b0;
                        if (ctl_sel[g] && is_ctrl[g] && reg_wdata_i[`EP_HS_BIT_SETUP_RX])
                            setup_rx[g] <= 1'b0;
                        if (ev_out[g])
                            out_rx[g] <= 1'b1;
                        else if (ctl_sel[g] && reg_wdata_i[`EP_HS_BIT_OUT_RX])
                            out_rx[g] <= 1'b0;
                        if (ev_in_done[g])
                            in_done[g] <= 1'b1;
                        else if (ctl_sel[g] && reg_wdata_i[`EP_HS_BIT_IN_DONE])
                            in_done[g] <= 1'b0;
                    end
                end
            end

            // interrupt causes; the clear of IN loaded interrupts when IN-done stands
            assign irq_hit[g] = irq_en[g] && (ev_setup[g] || ev_out[g]
                || ev_status_end[g]
                || (ev_in_clr[g] && (in_done[g] || ev_in_done[g])));
        end
    endgenerate

    // interrupt enables per endpoint, one bit each
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_en <= '0;
        end
        else if (clk_en_i && reg_wr_i && reg_addr_i == ADDR_W'(`EP_HS_IRQ_EN))
        begin
            irq_en <= reg_wdata_i[NUM_EP-1:0];
        end
    end

    // interrupt is a one-cycle pulse per event; no latch here, the cpu side holds it
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            irq_o <= |irq_hit;
        end
    end

    // read decode; function ep0 shares one address for control and status,
    // so a read there returns the status flags, which is what firmware polls
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_addr_i == ADDR_W'(`EP_HS_IRQ_EN))
        begin
            next_rdata = 8'(irq_en);
        end
        else
        begin
            for (int i = 0; i < NUM_EP; i++)
            begin
                if (sts_sel[i])
                begin
                    next_rdata = {4'h0, stall_sent[i], setup_rx[i] && is_ctrl[i],
                                  out_rx[i], in_done[i]};
                end
                else if (reg_addr_i == ((i == 0) ? ADDR_W'(`EP_HS_HUB_EP0_CTRL_ACK) :
                    (i == 2) ? ADDR_W'(`EP_HS_FN_EP1_CTRL_ACK) :
                    (i == 3) ? ADDR_W'(`EP_HS_FN_EP2_CTRL_ACK) :
                    (i == 4) ? ADDR_W'(`EP_HS_FN_EP3_CTRL_ACK) : ADDR_W'(0)) && i != 1)
                begin
                    // ack bits read zero since they are never stored
                    next_rdata = {dir_bit[i], data_end[i], stall_req[i], in_loaded[i],
                                  4'h0};
                end
            end
        end
    end

    // read data stands for one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_o <= `EP_HS_RESET_BYTE;
            fifo_write_ok_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
            fifo_write_ok_o <= ~|in_loaded;
        end
    end

endmodule // usb_endpoint_handshake_ctrl

// [core/ep_hs_cfg.svh]
// register offsets, field positions and reset values of the endpoint handshake block
`ifndef EP_HS_CFG_SVH
`define EP_HS_CFG_SVH
`define EP_HS_HUB_EP0_CTRL_ACK 13'h1FA7
`define EP_HS_FN_EP0_CTRL_ACK 13'h1FDD
`define EP_HS_FN_EP1_CTRL_ACK 13'h1FA4
`define EP_HS_FN_EP2_CTRL_ACK 13'h1FA3
`define EP_HS_FN_EP3_CTRL_ACK 13'h1FA2
`define EP_HS_HUB_EP0_STATUS 13'h1FDF
`define EP_HS_FN_EP1_STATUS 13'h1FDC
`define EP_HS_FN_EP2_STATUS 13'h1FDB
`define EP_HS_FN_EP3_STATUS 13'h1FDA
`define EP_HS_IRQ_EN 13'h1F00
`define EP_HS_BIT_DIR 7
`define EP_HS_BIT_DATA_END 6
`define EP_HS_BIT_STALL_REQ 5
`define EP_HS_BIT_IN_LOADED 4
`define EP_HS_BIT_STALL_SENT 3
`define EP_HS_BIT_SETUP_RX 2
`define EP_HS_BIT_OUT_RX 1
`define EP_HS_BIT_IN_DONE 0
`define EP_HS_RESET_BYTE 8'h00
`endif

// [core/ep_hs_pkg.sv]
// types shared by the endpoint handshake block
package ep_hs_pkg;
    typedef enum logic [2:0]
    {
        TOK_NONE = 3'b000,
        TOK_SETUP = 3'b001,
        TOK_IN = 3'b010,
        TOK_OUT = 3'b011
    } token_t;
    typedef enum logic [2:0]
    {
        HS_NONE = 3'b000,
        HS_ACK = 3'b001,
        HS_NAK = 3'b010,
        HS_STALL = 3'b011,
        HS_DATA = 3'b100
    } reply_t;
    typedef enum logic [1:0]
    {
        PH_IDLE = 2'b00,
        PH_DATA = 2'b01,
        PH_STATUS = 2'b10
    } phase_t;
endpackage

// [verif/usb_host_model.sv]
// host-side token model: drives the token, handshake and completion lines
`timescale 1ns/1ps
module usb_host_model
    import ep_hs_pkg::*;
(
    output logic [2:0] tok_ep_o,
    output logic [2:0] tok_kind_o,
    output logic tok_valid_o,
    output logic in_host_ack_o,
    output logic in_sent_o,
    output logic out_stored_o,
    output logic setup_stored_o
);
    initial
    begin
        tok_ep_o = 3'h0;
        tok_kind_o = 3'h0;
        tok_valid_o = 1'b0;
        in_host_ack_o = 1'b0;
        in_sent_o = 1'b0;
        out_stored_o = 1'b0;
        setup_stored_o = 1'b0;
    end
    // one call is one token cycle; idle lines invert so a stale value is never trusted
    task automatic drive(input logic t, input logic [2:0] e, input logic [2:0] k,
        input logic [1:0] f);
        tok_valid_o <= t;
        tok_ep_o <= t ? e : ~tok_ep_o;
        tok_kind_o <= t ? k : ~tok_kind_o;
        // completion lines only accompany the token kind they belong to
        in_host_ack_o <= t & f[1] & (k == TOK_IN);
        in_sent_o <= t & f[0] & (k == TOK_IN);
        out_stored_o <= t & f[0] & (k == TOK_OUT);
        setup_stored_o <= t & f[0] & (k == TOK_SETUP);
    endtask
endmodule // usb_host_model

// [verif/usb_endpoint_handshake_ctrl_properties.sv]
// port-level assertions for the endpoint handshake block
`timescale 1ns/1ps
`include "ep_hs_cfg.svh"
module usb_endpoint_handshake_ctrl_properties
    import ep_hs_pkg::*;
#(
    parameter int NUM_EP = 5,
    parameter int ADDR_W = 13
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [2:0] tok_ep_i,
    input wire logic [2:0] tok_kind_i,
    input wire logic tok_valid_i,
    input wire logic [NUM_EP-1:0] ep_iso_i,
    input wire logic in_host_ack_i,
    input wire logic in_sent_i,
    input wire logic out_stored_i,
    input wire logic setup_stored_i,
    input wire logic [2:0] reply_o,
    input wire logic reply_data1_o,
    input wire logic fifo_write_ok_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i || !clk_en_i);
    logic [7:0] irq_en;
    // shadow of the enables, so an OUT can be judged without seeing the body
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_en <= 8'h00;
        else if (clk_en_i && reg_wr_i && reg_addr_i == `EP_HS_IRQ_EN)
            irq_en <= reg_wdata_i;
    end
    AST_RD_IDLE_ZERO: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_SETUP_ACK: assert property (tok_valid_i && tok_kind_i == TOK_SETUP |=> reply_o == HS_ACK)
        else $error("setup token not acknowledged");
    AST_LOAD_BLOCKS: assert property (reg_wr_i && reg_wdata_i[4] && !tok_valid_i
        && reg_addr_i == `EP_HS_FN_EP1_CTRL_ACK |=> ##1 !fifo_write_ok_o)
        else $error("fifo still free after loading");
    AST_STALL_NEXT: assert property (reg_wr_i && reg_wdata_i[5]
        && reg_addr_i == `EP_HS_FN_EP3_CTRL_ACK ##1 tok_valid_i && tok_ep_i == 3'h4
        && tok_kind_i == TOK_IN |=> reply_o == HS_STALL)
        else $error("stall request not answered with stall");
    AST_NO_ACK_KEEPS: assert property (reg_wr_i && reg_wdata_i == 8'h10
        && reg_addr_i == `EP_HS_FN_EP1_CTRL_ACK ##1 tok_valid_i && tok_ep_i == 3'h2
        && tok_kind_i == TOK_IN && in_sent_i && !in_host_ack_i && !ep_iso_i[2]
        |=> reply_o == HS_DATA ##1 !fifo_write_ok_o)
        else $error("buffer released without host ack");
    AST_IN_DONE_READ: assert property (tok_valid_i && tok_ep_i == 3'h2
        && tok_kind_i == TOK_IN && in_host_ack_i ##1 reply_o == HS_DATA && reg_rd_i
        && reg_addr_i == `EP_HS_FN_EP1_STATUS |=> reg_rdata_o[0])
        else $error("in-done not set after acked data");
    AST_RSVD_ZERO: assert property (reg_rd_i && (reg_addr_i == `EP_HS_FN_EP1_STATUS
        || reg_addr_i == `EP_HS_FN_EP2_STATUS || reg_addr_i == `EP_HS_FN_EP3_STATUS)
        |=> reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[2])
        else $error("reserved status bits not zero");
    AST_ACK_CLEARS: assert property (reg_wr_i && reg_wdata_i[3:0] == 4'hF && !tok_valid_i
        && reg_addr_i == `EP_HS_FN_EP1_CTRL_ACK ##1 reg_rd_i && !tok_valid_i
        && reg_addr_i == `EP_HS_FN_EP1_STATUS |=> reg_rdata_o == 8'h00)
        else $error("acknowledge did not clear the status");
    AST_OUT_IRQ: assert property (tok_valid_i && tok_kind_i == TOK_OUT && tok_ep_i == 3'h2
        && out_stored_i && irq_en[2] |=> reply_o != HS_ACK || irq_o)
        else $error("stored out packet raised no interrupt");
    AST_OUT_NAK: assert property (tok_valid_i && tok_kind_i == TOK_OUT && tok_ep_i == 3'h2
        && out_stored_i && !reg_wr_i ##1 reply_o == HS_ACK && tok_valid_i && !reg_wr_i
        && tok_kind_i == TOK_OUT && tok_ep_i == 3'h2 |=> reply_o == HS_NAK)
        else $error("second out packet not refused");
endmodule // usb_endpoint_handshake_ctrl_properties
bind usb_endpoint_handshake_ctrl usb_endpoint_handshake_ctrl_properties
    #(.NUM_EP(NUM_EP), .ADDR_W(ADDR_W)) props (.clk_sys_i, .rst_n_i, .clk_en_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tok_ep_i, .tok_kind_i, .tok_valid_i,
    .ep_iso_i, .in_host_ack_i, .in_sent_i, .out_stored_i, .setup_stored_i, .reply_o,
    .reply_data1_o, .fifo_write_ok_o, .irq_o);

// [verif/usb_endpoint_handshake_ctrl_tb.sv]
// self-checking bench for the endpoint handshake block
`timescale 1ns/1ps
`include "ep_hs_cfg.svh"
module usb_endpoint_handshake_ctrl_tb import ep_hs_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic en = 1'b1;
    logic rd_seen = 1'b0;
    logic tv_seen = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic [7:0] wdata = 8'h00;
    logic [4:0] iso = 5'h00;
    logic [7:0] rdata, r;
    logic [2:0] ep, kind, reply;
    logic tv, ack, sent, ostor, sstor, d1, fifo_ok, irq;
    logic [12:0] a;
    logic [4:0] note;
    logic [7:0] exp_rd[$];
    logic [4:0] exp_rp[$];
    int n_fail = 0;
    int comparisons = 0;
    int seed = 35;
    int cycles = 0;
    logic [12:0] regs[11] = '{`EP_HS_HUB_EP0_CTRL_ACK, `EP_HS_FN_EP0_CTRL_ACK,
        `EP_HS_FN_EP1_CTRL_ACK, `EP_HS_FN_EP2_CTRL_ACK, `EP_HS_FN_EP3_CTRL_ACK,
        `EP_HS_HUB_EP0_STATUS, `EP_HS_FN_EP1_STATUS, `EP_HS_FN_EP2_STATUS,
        `EP_HS_FN_EP3_STATUS, `EP_HS_IRQ_EN, 13'h1000};
    usb_endpoint_handshake_ctrl dut
    (
        .clk_sys_i(clk),
        .rst_n_i(rst_n),
        .clk_en_i(en),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .tok_ep_i(ep),
        .tok_kind_i(kind),
        .tok_valid_i(tv),
        .ep_iso_i(iso),
        .in_host_ack_i(ack),
        .in_sent_i(sent),
        .out_stored_i(ostor),
        .setup_stored_i(sstor),
        .reply_o(reply),
        .reply_data1_o(d1),
        .fifo_write_ok_o(fifo_ok),
        .irq_o(irq)
    );
    usb_host_model host
    (
        .tok_ep_o(ep),
        .tok_kind_o(kind),
        .tok_valid_o(tv),
        .in_host_ack_o(ack),
        .in_sent_o(sent),
        .out_stored_o(ostor),
        .setup_stored_o(sstor)
    );
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one cycle of bus and token activity, launched together just after the edge
    task automatic cyc(input logic w, input logic r0, input logic [12:0] ad,
        input logic [7:0] d, input logic t, input logic [2:0] e, input logic [2:0] k,
        input logic [1:0] f);
        @(posedge clk);
        wr <= w;
        rd <= r0;
        addr <= ad;
        wdata <= d;
        host.drive(t, e, k, f);
    endtask
    task automatic wrt(input logic [12:0] ad, input logic [7:0] d);
        cyc(1'b1, 1'b0, ad, d, 1'b0, 3'h0, TOK_NONE, 2'h0);
    endtask
    task automatic rdx(input logic [12:0] ad, input logic [7:0] x);
        exp_rd.push_back(x);
        cyc(1'b0, 1'b1, ad, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
    endtask
    // note layout is irq, data1, reply
    task automatic tok(input logic [2:0] e, input logic [2:0] k, input logic [1:0] f,
        input logic [4:0] x);
        exp_rp.push_back(x);
        cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b1, e, k, f);
    endtask
    // answers stand one cycle, so remember which edge asked and look mid-cycle
    always @(posedge clk)
    begin
        rd_seen <= rd;
        tv_seen <= tv;
        cycles++;
        if (cycles == 1000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    always @(negedge clk)
    begin
        if (rd_seen && exp_rd.size() > 0)
            check("read data", exp_rd.pop_front(), rdata);
        note = 5'h00;
        if (tv_seen && exp_rp.size() > 0)
            note = exp_rp.pop_front();
        if (tv_seen)
            check("reply", {5'h00, note[2:0]}, {5'h00, reply});
        if (tv_seen)
            check("data1", {7'h00, note[3]}, {7'h00, d1});
        check("interrupt", {7'h00, note[4]}, {7'h00, irq});
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
        foreach (regs[i]) rdx(regs[i], 8'h00);
        // random control values; only the defined upper bits may read back
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 3) ? `EP_HS_HUB_EP0_CTRL_ACK : 13'h1FA4 - 13'(i);
            r = 8'($random(seed));
            wrt(a, r);
            rdx(a, (i == 3) ? {r[7:4], 4'h0} : {1'b0, r[6:4], 4'h0});
            wrt(a, 8'h00);
        end
        wrt(13'h1000, 8'hFF);
        rdx(13'h1000, 8'h00);
        wrt(`EP_HS_IRQ_EN, 8'h07);
        wrt(`EP_HS_FN_EP1_CTRL_ACK, 8'h10);
        tok(3'h2, TOK_IN, 2'h1, {2'b00, HS_DATA});
        rdx(`EP_HS_FN_EP1_CTRL_ACK, 8'h10);
        @(negedge clk) check("fifo free", 8'h00, {7'h00, fifo_ok});
        tok(3'h2, TOK_IN, 2'h3, {2'b10, HS_DATA});
        rdx(`EP_HS_FN_EP1_STATUS, 8'h01);
        wrt(`EP_HS_FN_EP1_CTRL_ACK, 8'h0F);
        rdx(`EP_HS_FN_EP1_STATUS, 8'h00);
        rdx(`EP_HS_FN_EP1_CTRL_ACK, 8'h00);
        wrt(`EP_HS_FN_EP2_CTRL_ACK, 8'h10);
        iso <= 5'h08;
        tok(3'h3, TOK_IN, 2'h1, {2'b00, HS_DATA});
        rdx(`EP_HS_FN_EP2_CTRL_ACK, 8'h00);
        // the free flag is registered from the loaded bits, so it trails them a cycle
        cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
        @(negedge clk) check("fifo free", 8'h01, {7'h00, fifo_ok});
        wrt(`EP_HS_FN_EP3_CTRL_ACK, 8'h20);
        tok(3'h4, TOK_IN, 2'h0, {2'b00, HS_STALL});
        tok(3'h4, TOK_OUT, 2'h0, {2'b00, HS_STALL});
        rdx(`EP_HS_FN_EP3_STATUS, 8'h08);
        wrt(`EP_HS_FN_EP3_CTRL_ACK, 8'h08);
        rdx(`EP_HS_FN_EP3_STATUS, 8'h00);
        tok(3'h2, TOK_OUT, 2'h1, {2'b10, HS_ACK});
        tok(3'h2, TOK_OUT, 2'h1, {2'b00, HS_NAK});
        rdx(`EP_HS_FN_EP1_STATUS, 8'h02);
        wrt(`EP_HS_FN_EP1_CTRL_ACK, 8'h02);
        rdx(`EP_HS_FN_EP1_STATUS, 8'h00);
        wrt(`EP_HS_FN_EP0_CTRL_ACK, 8'h20);
        tok(3'h1, TOK_OUT, 2'h0, {2'b00, HS_STALL});
        wrt(`EP_HS_FN_EP0_CTRL_ACK, 8'h00);
        rdx(`EP_HS_FN_EP0_CTRL_ACK, 8'h08);
        tok(3'h1, TOK_SETUP, 2'h1, {2'b10, HS_ACK});
        rdx(`EP_HS_FN_EP0_CTRL_ACK, 8'h04);
        wrt(`EP_HS_FN_EP0_CTRL_ACK, 8'h04);
        rdx(`EP_HS_FN_EP0_CTRL_ACK, 8'h00);
        tok(3'h0, TOK_SETUP, 2'h1, {2'b10, HS_ACK});
        wrt(`EP_HS_HUB_EP0_CTRL_ACK, 8'h44);
        // status phase opens one cycle after the last-packet write lands
        cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
        tok(3'h0, TOK_IN, 2'h3, {2'b11, HS_DATA});
        rdx(`EP_HS_HUB_EP0_CTRL_ACK, 8'h40);
        rdx(`EP_HS_HUB_EP0_STATUS, 8'h01);
        // a write presented while the enable is low must leave no trace
        repeat (2) cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
        en <= 1'b0;
        wrt(`EP_HS_FN_EP1_CTRL_ACK, 8'h10);
        cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
        en <= 1'b1;
        rdx(`EP_HS_FN_EP1_CTRL_ACK, 8'h00);
        repeat (3) cyc(1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, 3'h0, TOK_NONE, 2'h0);
        wrap_up();
    end
endmodule // usb_endpoint_handshake_ctrl_tb
